// ---- hw/lsnp_pkg.sv ----
package lsnp_pkg;

    // lane and converter geometry
    localparam int LSNP_CONVERTERS   = 16;
    localparam int LSNP_LANES        = 8;
    localparam int LSNP_MAX_PER_LANE = 8;
    localparam int LSNP_SAMPLE_BITS  = 16;
    localparam int LSNP_FRAME_BITS   = 128;
    localparam int LSNP_OCTET_BITS   = 8;

    // converters_per_lane codes
    localparam logic [1:0] LSNP_CPL_8 = 2'h0;
    localparam logic [1:0] LSNP_CPL_4 = 2'h1;
    localparam logic [1:0] LSNP_CPL_2 = 2'h2;

    // sample_resolution / serialization_width codes
    localparam logic [1:0] LSNP_W_10 = 2'h0;
    localparam logic [1:0] LSNP_W_12 = 2'h1;
    localparam logic [1:0] LSNP_W_14 = 2'h2;
    localparam logic [1:0] LSNP_W_16 = 2'h3;

    // values after reset
    localparam logic [7:0] LSNP_ACTIVE_RESET = 8'h11;
    localparam logic [4:0] LSNP_F_RESET      = 5'h0a;
    localparam logic       LSNP_READY_RESET  = 1'b1;

    typedef struct packed {
        logic [1:0] convertersPerLane;
        logic [1:0] sampleResolution;
        logic [1:0] serializationWidth;
    } lsnp_cfg_type;

    typedef struct packed {
        logic [7:0] octet;
        logic       valid;
        logic       frameStart;
        logic       frameEnd;
    } lsnp_octet_type;

    typedef logic [LSNP_CONVERTERS-1:0][LSNP_SAMPLE_BITS-1:0]
        lsnp_samples_type;

    function automatic logic [4:0] lsnp_width(input logic [1:0] code);
        case (code)
            LSNP_W_10: lsnp_width = 5'd10;
            LSNP_W_12: lsnp_width = 5'd12;
            LSNP_W_14: lsnp_width = 5'd14;
            default:   lsnp_width = 5'd16;
        endcase
    endfunction

endpackage

// ---- hw/lsnp_octet_shifter.sv ----
`timescale 1ns/1ps
module lsnp_octet_shifter (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          load,
    input  wire logic [lsnp_pkg::LSNP_FRAME_BITS-1:0] frame,
    input  wire logic [4:0]                    octets,
    output lsnp_pkg::lsnp_octet_type           laneOut,
    output logic                               ready
);
    import lsnp_pkg::*;

    logic [LSNP_FRAME_BITS-1:0] shiftReg;
    logic [4:0]                 remain;
    wire                        take    = load && ready;
    wire                        lastOne = (remain == 5'd1);

    // first-listed nibble leaves in bits 7:4
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shiftReg <= '0;
            remain   <= '0;
            laneOut  <= '0;
            ready    <= LSNP_READY_RESET;
        end else if (take) begin
            shiftReg         <= frame << LSNP_OCTET_BITS;
            laneOut.octet    <= frame[LSNP_FRAME_BITS-1 -: LSNP_OCTET_BITS];
            laneOut.valid    <= 1'b1;
            laneOut.frameStart <= 1'b1;
            laneOut.frameEnd <= (octets == 5'd1);
            remain           <= octets - 5'd1;
            ready            <= (octets == 5'd1);
        end else if (remain != 5'd0) begin
            shiftReg         <= shiftReg << LSNP_OCTET_BITS;
            laneOut.octet    <= shiftReg[LSNP_FRAME_BITS-1 -: LSNP_OCTET_BITS];
            laneOut.valid    <= 1'b1;
            laneOut.frameStart <= 1'b0;
            laneOut.frameEnd <= lastOne;
            remain           <= remain - 5'd1;
            ready            <= lastOne;
        end else begin
            laneOut.valid    <= 1'b0;
            laneOut.frameStart <= 1'b0;
            laneOut.frameEnd <= 1'b0;
            ready            <= 1'b1;
        end
    end

endmodule

// ---- hw/lane_sample_nibble_packer.sv ----
`timescale 1ns/1ps
module lane_sample_nibble_packer (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  lsnp_pkg::lsnp_cfg_type         cfg,
    input  wire logic                      sampleValid,
    input  lsnp_pkg::lsnp_samples_type     samples,
    output lsnp_pkg::lsnp_octet_type [lsnp_pkg::LSNP_LANES-1:0] laneOut,
    output logic [lsnp_pkg::LSNP_LANES-1:0] laneActive,
    output logic [4:0]                     octetsPerFrame,
    output logic                           sampleReady
);
    import lsnp_pkg::*;

    // words on one lane for a converter count
    function automatic logic [3:0] lsnp_count(
        input logic [1:0] cplCode
    );
        logic [3:0] count;

        case (cplCode)
            LSNP_CPL_2: begin
                count = 4'd2;
            end
            LSNP_CPL_4: begin
                count = 4'd4;
            end
            default: begin
                count = 4'd8;
            end
        endcase
        return count;
    endfunction

    // lanes that carry data for a converter count
    function automatic logic lsnp_lane_on(
        input logic [1:0] cplCode,
        input int         lane
    );
        logic on;

        case (cplCode)
            LSNP_CPL_2: begin
                on = 1'b1;
            end
            LSNP_CPL_4: begin
                on = (lane % 2 == 0);
            end
            default: begin
                on = (lane % 4 == 0);
            end
        endcase
        return on;
    endfunction

    // first converter of a lane, counted from zero
    function automatic int lsnp_lane_base(
        input int lane
    );
        int base;

        base = 2 * lane;
        return base;
    endfunction

    // two per lane rounds each word up to 12 or 16 bits
    function automatic logic [4:0] lsnp_word_bits(
        input logic [1:0] cplCode,
        input logic [4:0] serW
    );
        logic [4:0] bits;

        bits = serW;
        if (cplCode == LSNP_CPL_2) begin
            if (serW <= 5'd12) begin
                bits = 5'd12;
            end else begin
                bits = 5'd16;
            end
        end
        return bits;
    endfunction

    // octets per frame from words per lane and word width
    function automatic logic [4:0] lsnp_frame_octets(
        input logic [3:0] count,
        input logic [4:0] wbits
    );
        logic [8:0] used;

        used = 9'(count * wbits);
        return used[7:3];
    endfunction

    // zeros below lsb up to word width
    function automatic logic [15:0] lsnp_pad(
        input logic [15:0] raw,
        input logic [4:0]  res,
        input logic [4:0]  pad
    );
        logic [15:0] mask;

        mask = 16'hffff >> (5'd16 - res);
        return (raw & mask) << pad;
    endfunction

    // one padded word of a lane, zero past the last converter
    function automatic logic [15:0] lsnp_lane_word(
        input lsnp_samples_type smp,
        input int               idx,
        input logic [4:0]       res,
        input logic [4:0]       wbits
    );
        logic [15:0] raw;

        raw = 16'h0000;
        if (idx < LSNP_CONVERTERS) begin
            raw = smp[idx % LSNP_CONVERTERS];
        end
        return lsnp_pad(raw, res, wbits - res);
    endfunction

    // msb first, ascending converters, no gaps
    function automatic logic [LSNP_FRAME_BITS-1:0] lsnp_pack(
        input lsnp_samples_type smp,
        input int               base,
        input logic [3:0]       count,
        input logic [4:0]       res,
        input logic [4:0]       wbits
    );
        logic [LSNP_FRAME_BITS-1:0] acc;
        logic [8:0]                 used;

        acc  = '0;
        used = 9'(count * wbits);
        for (int i = 0; i < LSNP_MAX_PER_LANE; i++) begin
            if (4'(i) < count) begin
                acc = (acc << wbits) |
                      {112'h0, lsnp_lane_word(smp, base + i, res, wbits)};
            end
        end
        // left-align so the first word leaves first
        return acc << (9'd128 - used);
    endfunction

    // configuration decode
    wire [4:0] resBits  = lsnp_width(cfg.sampleResolution);
    wire [4:0] serRaw   = lsnp_width(cfg.serializationWidth);

    // width below resolution is not legal; clamp it up
    wire [4:0] serBits  = (serRaw < resBits) ? resBits : serRaw;

    wire [3:0] cplCount = lsnp_count(cfg.convertersPerLane);
    wire [4:0] wordBits = lsnp_word_bits(cfg.convertersPerLane, serBits);
    wire [4:0] frameOct = lsnp_frame_octets(cplCount, wordBits);

    // lanes that carry data for the chosen converter count
    logic [LSNP_LANES-1:0] next_laneActive;
    logic [LSNP_LANES-1:0] laneReady;
    wire                   frameTake;

    // lane 0 paces every take, so an idle lane never starts alone
    // while the others are still busy; a refused request leaves no trace
    assign frameTake = sampleValid && laneReady[0];

    genvar g;
    generate
        for (g = 0; g < LSNP_LANES; g++) begin : lanes
            wire                       laneOn;
            wire [LSNP_FRAME_BITS-1:0] frame;

            // each lane starts at converter 2*lane, ascending
            assign laneOn = lsnp_lane_on(cfg.convertersPerLane, g);
            assign next_laneActive[g] = laneOn;
            assign frame = lsnp_pack(samples, lsnp_lane_base(g), cplCount,
                                     resBits, wordBits);

            lsnp_octet_shifter u_shift (
                .clk_sys (clk_sys),
                .rst     (rst),
                .load    (frameTake && laneOn),
                .frame   (frame),
                .octets  (frameOct),
                .laneOut (laneOut[g]),
                .ready   (laneReady[g])
            );
        end
    endgenerate

    // lane 0 is always active and sets the frame pace
    assign sampleReady = laneReady[0];

    // lane map follows each taken frame
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            laneActive <= LSNP_ACTIVE_RESET;
        end else if (frameTake) begin
            laneActive <= next_laneActive;
        end
    end

    // frame size follows each taken frame
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            octetsPerFrame <= LSNP_F_RESET;
        end else if (frameTake) begin
            octetsPerFrame <= frameOct;
        end
    end

endmodule

// ---- bench/lsnp_asserts.sv ----
`timescale 1ns/1ps
module lsnp_asserts (
    input wire logic                    clk_sys,
    input wire logic                    rst,
    input wire logic                    sampleValid,
    input lsnp_pkg::lsnp_octet_type [7:0] laneOut,
    input wire logic [7:0]              laneActive,
    input wire logic [4:0]              octetsPerFrame,
    input wire logic                    sampleReady
);
    import lsnp_pkg::*;
    logic [4:0] cnt;
    logic [7:0] vAll;
    wire        take = sampleValid && sampleReady;
    wire        v0 = laneOut[0].valid;
    wire        e0 = laneOut[0].frameEnd;
    always_comb for (int l = 0; l < 8; l++) vAll[l] = laneOut[l].valid;
    always_ff @(posedge clk_sys or posedge rst)
        if (rst) cnt <= 5'h0;
        else if (v0) cnt <= e0 ? 5'h0 : cnt + 5'h1;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    first_octet_a: assert property (
        take |=> v0 && laneOut[0].frameStart)
        else $error("no first octet");
    frame_count_a: assert property (
        v0 && e0 |-> cnt == octetsPerFrame - 5'h1)
        else $error("octet count wrong");
    octet_burst_a: assert property (v0 && !e0 |=> v0)
        else $error("gap in frame");
    end_ready_a: assert property (e0 |-> sampleReady)
        else $error("not ready at end");
    idle_lane_a: assert property (~|(vAll & ~laneActive))
        else $error("inactive lane valid");
    lane_pair_a: assert property (vAll[4] == v0)
        else $error("lane 4 out of step");
    cfg_hold_a: assert property (!take |=> $stable(octetsPerFrame))
        else $error("frame size moved");
    busy_start_a: assert property (
        $fell(sampleReady) |-> laneOut[0].frameStart)
        else $error("busy without start");
    c_take: cover property (take);
    c_b2b: cover property (e0 && take);
    c_f16: cover property (e0 && octetsPerFrame == 5'h10);
endmodule
bind lane_sample_nibble_packer lsnp_asserts u_chk (.clk_sys, .rst,
    .sampleValid, .laneOut, .laneActive, .octetsPerFrame, .sampleReady);

// ---- bench/lsnp_rx_model.sv ----
`timescale 1ns/1ps
module lsnp_rx_model (
    input wire logic                clk_sys,
    input wire logic                rst,
    input lsnp_pkg::lsnp_octet_type lane,
    output logic [127:0]            frameBits,
    output logic                    done
);
    import lsnp_pkg::*;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            frameBits <= '0;
            done <= 1'b0;
        end else begin
            done <= lane.valid && lane.frameEnd;
            // octets arrive msb first
            if (lane.valid)
                frameBits <= lane.frameStart ? 128'(lane.octet)
                                             : {frameBits[119:0], lane.octet};
        end
    end
endmodule

// ---- bench/lane_sample_nibble_packer_bench.sv ----
`timescale 1ns/1ps
module lane_sample_nibble_packer_bench;
    import lsnp_pkg::*;
    logic             clk_sys = 1'b0;
    logic             rst = 1'b1;
    lsnp_cfg_type     cfg = '0;
    logic             sampleValid = 1'b0;
    lsnp_samples_type samples = '0;
    lsnp_octet_type [LSNP_LANES-1:0] laneOut;
    logic [7:0]       laneActive;
    logic [4:0]       octetsPerFrame;
    logic             sampleReady;
    logic [127:0]     fb0, fb4;
    logic             d0;
    int               n_errors = 0;
    int               samples_checked = 0;
    int               cycles = 0;
    lane_sample_nibble_packer u_dut (.clk_sys, .rst, .cfg, .sampleValid,
        .samples, .laneOut, .laneActive, .octetsPerFrame, .sampleReady);
    lsnp_rx_model u_rx0 (.clk_sys, .rst, .lane(laneOut[0]),
        .frameBits(fb0), .done(d0));
    lsnp_rx_model u_rx4 (.clk_sys, .rst, .lane(laneOut[4]),
        .frameBits(fb4), .done());
    initial forever #5 clk_sys = ~clk_sys;
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic check(input string nm, input logic [127:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [127:0] want(int n, int r, int np, int b);
        logic [127:0] a;
        a = '0;
        for (int k = 0; k < n; k++)
            a = (a << np) | ((128'(samples[b+k]) & ((128'h1 << r) - 1))
                             << (np - r));
        return a;
    endfunction
    task automatic run(input logic [1:0] c, r, s, input logic [7:0] act);
        int n, np, t;
        n = c == LSNP_CPL_8 ? 8 : c == LSNP_CPL_4 ? 4 : 2;
        np = n == 2 ? (s > LSNP_W_12 ? 16 : 12) : 10 + 2 * s;
        t = 0;
        @(negedge clk_sys);
        cfg = '{c, r, s};
        sampleValid = 1'b1;
        @(negedge clk_sys);
        cfg.convertersPerLane = LSNP_CPL_2; // refused while busy
        @(negedge clk_sys);
        sampleValid = 1'b0;
        while (d0 !== 1'b1 && t < 40) begin
            @(negedge clk_sys);
            t++;
        end
        check("lane0", fb0, want(n, 10 + 2 * r, np, 0));
        check("lane4", fb4, want(n, 10 + 2 * r, np, 8));
        check("octets", 128'(octetsPerFrame), 128'(n * np / 8));
        check("active", 128'(laneActive), 128'(act));
    endtask
    initial begin
        for (int k = 0; k < 16; k++)
            samples[k] = 16'h9d4b + 16'(k) * 16'h1357;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        check("rfof", 128'(octetsPerFrame), 128'(LSNP_F_RESET));
        check("rmap", 128'(laneActive), 128'(LSNP_ACTIVE_RESET));
        run(LSNP_CPL_8, LSNP_W_10, LSNP_W_10, 8'h11);
        run(LSNP_CPL_8, LSNP_W_12, LSNP_W_12, 8'h11);
        run(LSNP_CPL_8, LSNP_W_14, LSNP_W_14, 8'h11);
        run(LSNP_CPL_8, LSNP_W_16, LSNP_W_16, 8'h11);
        run(LSNP_CPL_8, LSNP_W_10, LSNP_W_12, 8'h11);
        run(LSNP_CPL_8, LSNP_W_12, LSNP_W_14, 8'h11);
        run(LSNP_CPL_8, LSNP_W_14, LSNP_W_16, 8'h11);
        run(LSNP_CPL_4, LSNP_W_12, LSNP_W_14, 8'h55);
        run(LSNP_CPL_2, LSNP_W_10, LSNP_W_10, 8'hff);
        run(LSNP_CPL_2, LSNP_W_14, LSNP_W_16, 8'hff);
        test_done();
    end
endmodule
